//--- verilog/evtmr_pkg.sv
// Package of constants and types for the event triggered countdown timer pair.
package evtmr_pkg;

   // Register indices as printed; byte address is four times the index.
   localparam logic [7:0]  FIRST_STATUS_IDX  = 8'h08;
   localparam logic [7:0]  SECOND_STATUS_IDX = 8'h09;
   localparam logic [7:0]  FIRST_PRESET_IDX  = 8'h0B;
   localparam logic [7:0]  SECOND_PRESET_IDX = 8'h0C;
   localparam logic [7:0]  FIRST_CFG_IDX     = 8'h0E;
   localparam logic [7:0]  SECOND_CFG_IDX    = 8'h0F;

   // Configuration field positions.
   localparam int CFG_ON           = 0;
   localparam int CFG_AUTO_RELOAD  = 1;
   localparam int CFG_CLK_SRC      = 2;
   localparam int CFG_DIV_LSB      = 3;
   localparam int CFG_START_NOW    = 6;
   localparam int CFG_GO_OWN_DOWN  = 7;
   localparam int CFG_GO_OWN_UP    = 8;
   localparam int CFG_GO_FAR_DOWN  = 9;
   localparam int CFG_GO_FAR_UP    = 10;
   localparam int CFG_GO_TX_END    = 11;
   localparam int CFG_GO_TX_BEGIN  = 12;
   localparam int CFG_GO_RX_END    = 13;
   localparam int CFG_GO_RX_BEGIN  = 14;
   localparam int CFG_HALT_OWN_DN  = 15;
   localparam int CFG_HALT_OWN_UP  = 16;
   localparam int CFG_HALT_FAR_DN  = 17;
   localparam int CFG_HALT_FAR_UP  = 18;
   localparam int CFG_HALT_TX_BEG  = 19;
   localparam int CFG_HALT_RX_BEG  = 20;
   localparam int STATUS_RUN_BIT   = 20;

   localparam int CNT_W = 20;
   localparam int CFG_W = 21;

   // Reset values.
   localparam logic [CFG_W-1:0] CFG_RESET    = 21'h00000;
   localparam logic [CNT_W-1:0] PRESET_RESET = 20'h00000;

   // Prescaler: 13.56 MHz base clock; code 0 is base/2, each code halves again.
   localparam logic [7:0] PRESCALE_W = 8'h08;

   typedef enum logic [0:0]
   {
      TMR_IDLE = 1'b0,
      TMR_RUN  = 1'b1
   } evtmr_state_t;

endpackage

//--- verilog/evtmr_tick.sv
// Shared prescaler producing the divided count enables from the base tick.
`timescale 1ns/1ns
`default_nettype none
module evtmr_tick
   import evtmr_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_ce,
   // Frontend clock enable pulse
   input  wire logic        i_base_tick,
   // One-cycle tick per divider code, bit n is base/2^(n+1)
   output logic [7:0]       o_div_tick
);

   typedef struct packed
   {
      logic [7:0] cnt;
   } evtmr_tick_st_t;

   evtmr_tick_st_t s_r;
   evtmr_tick_st_t s_nxt;
   logic [7:0]     inc;
   logic           ones;

   always_comb
   begin
      s_nxt = s_r;
      inc   = s_r.cnt + 8'h01;
      if (i_base_tick)
      begin
         s_nxt.cnt = inc;
      end
   end

   // A tick of base/2^(n+1) falls where the low n+1 count bits are all ones.
   // The running AND avoids a part-select whose width depends on the loop index.
   always_comb
   begin
      ones = 1'b1;
      for (int n = 0; n < 8; n++)
      begin
         ones          = ones && s_r.cnt[n];
         o_div_tick[n] = i_base_tick && ones;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         s_r <= '0;
      end
      else if (i_ce)
      begin
         s_r <= s_nxt;
      end
   end

endmodule
`default_nettype wire

//--- verilog/evtmr_core.sv
// One countdown timer with event start and stop triggers.
`timescale 1ns/1ns
`default_nettype none
module evtmr_core
   import evtmr_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_ce,
   // Configuration
   input  wire logic [CFG_W-1:0]  i_cfg,
   input  wire logic [CNT_W-1:0]  i_preset,
   input  wire logic              i_cfg_wr,
   // Rate enables
   input  wire logic              i_base_tick,
   input  wire logic [7:0]        i_div_tick,
   // Transceiver and field events, one-cycle pulses
   input  wire logic              i_rx_begin,
   input  wire logic              i_rx_nibble,
   input  wire logic              i_rx_end,
   input  wire logic              i_tx_begin,
   input  wire logic              i_tx_end,
   input  wire logic              i_far_up,
   input  wire logic              i_far_down,
   input  wire logic              i_own_up,
   input  wire logic              i_own_down,
   // State
   output logic [CNT_W-1:0]       o_count,
   output logic                   o_running
);

   typedef struct packed
   {
      evtmr_state_t     st;
      logic [CNT_W-1:0] cnt;
   } evtmr_core_st_t;

   evtmr_core_st_t s_r;
   evtmr_core_st_t s_nxt;
   logic           tick;
   logic           go;
   logic           halt;

   always_comb
   begin
      s_nxt = s_r;
      // Source selection: base clock or divided rate.
      tick = i_cfg[CFG_CLK_SRC] ? i_div_tick[i_cfg[CFG_DIV_LSB+:3]] : i_base_tick;
      go   = (i_cfg_wr && i_cfg[CFG_START_NOW])
          || (i_cfg[CFG_GO_RX_BEGIN] && i_rx_begin)
          || (i_cfg[CFG_GO_RX_END]   && i_rx_end)
          || (i_cfg[CFG_GO_TX_BEGIN] && i_tx_begin)
          || (i_cfg[CFG_GO_TX_END]   && i_tx_end)
          || (i_cfg[CFG_GO_FAR_UP]   && i_far_up)
          || (i_cfg[CFG_GO_FAR_DOWN] && i_far_down)
          || (i_cfg[CFG_GO_OWN_UP]   && i_own_up)
          || (i_cfg[CFG_GO_OWN_DOWN] && i_own_down);
      halt = (i_cfg[CFG_HALT_RX_BEG] && i_rx_nibble)
          || (i_cfg[CFG_HALT_TX_BEG] && i_tx_begin)
          || (i_cfg[CFG_HALT_FAR_UP] && i_far_up)
          || (i_cfg[CFG_HALT_FAR_DN] && i_far_down)
          || (i_cfg[CFG_HALT_OWN_UP] && i_own_up)
          || (i_cfg[CFG_HALT_OWN_DN] && i_own_down);
      if (!i_cfg[CFG_ON])
      begin
         // Clearing the enable stops the timer and ignores all triggers.
         s_nxt.st = TMR_IDLE;
      end
      else if (halt)
      begin
         // A stop wins over a simultaneous start so a stale start cannot revive it.
         s_nxt.st = TMR_IDLE;
      end
      else if (go)
      begin
         s_nxt.st  = TMR_RUN;
         s_nxt.cnt = i_preset;
      end
      else
      begin
         case (s_r.st)
            TMR_RUN:
            begin
               if (tick)
               begin
                  if (s_r.cnt <= 20'h00001)
                  begin
                     // Expiry on reaching zero.
                     if (i_cfg[CFG_AUTO_RELOAD])
                     begin
                        s_nxt.cnt = i_preset;
                     end
                     else
                     begin
                        s_nxt.cnt = '0;
                        s_nxt.st  = TMR_IDLE;
                     end
                  end
                  else
                  begin
                     s_nxt.cnt = s_r.cnt - 20'h00001;
                  end
               end
            end
            TMR_IDLE:
            begin
               s_nxt.st = TMR_IDLE;
            end
            default:
            begin
               s_nxt.st = TMR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         s_r <= '{st: TMR_IDLE, cnt: '0};
      end
      else if (i_ce)
      begin
         s_r <= s_nxt;
      end
   end

   assign o_count   = s_r.cnt;
   assign o_running = (s_r.st == TMR_RUN);

endmodule
`default_nettype wire

//--- verilog/evtmr_top.sv
// Top of the event triggered countdown timer pair with its APB register slave.
//
// Function
// - Start-now bit starts timer at once
// - Divider code picks 6.78 MHz to 53 kHz
// - Clock source bit: base or divided rate
// - No reload: stop and stay at zero
// - Reload: load preset, keep counting down
// - Triggers act only while enable is set
// - Halt after first four received bits
// - Halt when transmission begins
// - Halt when external field appears
// - Halt when external field is lost
// - Halt when own field switches on
// - Halt when own field switches off
// - Start on first received bit
// - Start when reception ends
// - Readable 20-bit count and running flag
// - Writable 20-bit preset, reset zero
// - Start on transmission begin or end
// - Start on field up/down events
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module evtmr_top
   import evtmr_pkg::*;
(
   // Clock, reset and enable
   input  wire logic         I_CLK_SYS,
   input  wire logic         I_NRST,
   input  wire logic         I_CE,
   // Frontend 13.56 MHz clock enable pulse
   input  wire logic         I_FE_TICK,
   // APB slave
   input  wire logic         I_PSEL,
   input  wire logic         I_PENABLE,
   input  wire logic         I_PWRITE,
   input  wire logic [7:0]   I_PADDR,
   input  wire logic [31:0]  I_PWDATA,
   output logic [31:0]       O_PRDATA,
   output logic              O_PREADY,
   output logic              O_PSLVERR,
   // Transceiver and field events, one-cycle pulses
   input  wire logic         I_RX_BEGIN,
   input  wire logic         I_RX_NIBBLE,
   input  wire logic         I_RX_END,
   input  wire logic         I_TX_BEGIN,
   input  wire logic         I_TX_END,
   input  wire logic         I_FAR_FIELD_UP,
   input  wire logic         I_FAR_FIELD_DOWN,
   input  wire logic         I_OWN_FIELD_UP,
   input  wire logic         I_OWN_FIELD_DOWN,
   // Timer state
   output logic              O_FIRST_RUNNING,
   output logic              O_SECOND_RUNNING
);

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      logic [1:0][CFG_W-1:0] cfg;
      logic [1:0][CNT_W-1:0] preset;
      logic [1:0]            cfg_wr;
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
      logic [1:0]            running;
   } evtmr_top_st_t;

   evtmr_top_st_t         s_r;
   evtmr_top_st_t         s_nxt;
   logic [7:0]            div_tick;
   logic [1:0][CNT_W-1:0] count;
   logic [1:0]            run;
   logic                  setup;
   logic                  access;
   logic [5:0]            idx;
   logic                  aligned;
   logic                  hit;
   logic [31:0]           rd_word;
   logic [1:0]            wr_preset;
   logic [1:0]            wr_cfg;

   ////////////////////////////////////////////////////////////////////////////////
   evtmr_tick u_tick
   (
      .i_clk       (I_CLK_SYS),
      .i_nrst      (I_NRST),
      .i_ce        (I_CE),
      .i_base_tick (I_FE_TICK),
      .o_div_tick  (div_tick)
   );

   // Both timers are the same core with their own registers.
   for (genvar t = 0; t < 2; t++)
   begin : g_tmr
      evtmr_core u_core
      (
         .i_clk       (I_CLK_SYS),
         .i_nrst      (I_NRST),
         .i_ce        (I_CE),
         .i_cfg       (s_r.cfg[t]),
         .i_preset    (s_r.preset[t]),
         .i_cfg_wr    (s_r.cfg_wr[t]),
         .i_base_tick (I_FE_TICK),
         .i_div_tick  (div_tick),
         .i_rx_begin  (I_RX_BEGIN),
         .i_rx_nibble (I_RX_NIBBLE),
         .i_rx_end    (I_RX_END),
         .i_tx_begin  (I_TX_BEGIN),
         .i_tx_end    (I_TX_END),
         .i_far_up    (I_FAR_FIELD_UP),
         .i_far_down  (I_FAR_FIELD_DOWN),
         .i_own_up    (I_OWN_FIELD_UP),
         .i_own_down  (I_OWN_FIELD_DOWN),
         .o_count     (count[t]),
         .o_running   (run[t])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode shared by the setup cycle (read data, error) and the access
   // cycle (write strobes). The two low address bits must be zero.
   always_comb
   begin
      idx       = I_PADDR[7:2];
      aligned   = (I_PADDR[1:0] == 2'b00);
      hit       = 1'b0;
      rd_word   = 32'h00000000;
      wr_preset = 2'b00;
      wr_cfg    = 2'b00;
      case ({2'b00, idx})
         FIRST_STATUS_IDX:
         begin
            hit     = 1'b1;
            rd_word = {11'h000, run[0], count[0]};
         end
         SECOND_STATUS_IDX:
         begin
            hit     = 1'b1;
            rd_word = {11'h000, run[1], count[1]};
         end
         FIRST_PRESET_IDX:
         begin
            hit          = 1'b1;
            rd_word      = {12'h000, s_r.preset[0]};
            wr_preset[0] = 1'b1;
         end
         SECOND_PRESET_IDX:
         begin
            hit          = 1'b1;
            rd_word      = {12'h000, s_r.preset[1]};
            wr_preset[1] = 1'b1;
         end
         FIRST_CFG_IDX:
         begin
            hit       = 1'b1;
            rd_word   = {11'h000, s_r.cfg[0]};
            wr_cfg[0] = 1'b1;
         end
         SECOND_CFG_IDX:
         begin
            hit       = 1'b1;
            rd_word   = {11'h000, s_r.cfg[1]};
            wr_cfg[1] = 1'b1;
         end
         default:
         begin
            hit = 1'b0;
         end
      endcase
      if (!aligned)
      begin
         hit = 1'b0;
      end
   end

   // The setup cycle is answered in the following access cycle, so pready is a
   // one-cycle pulse from a flop. Read data is taken at setup, but a write lands
   // only at the access edge where the master samples pready, so a refused or
   // abandoned transfer leaves the registers untouched.
   always_comb
   begin
      s_nxt         = s_r;
      s_nxt.cfg_wr  = 2'b00;
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.running = run;
      setup         = I_PSEL && !I_PENABLE;
      access        = I_PSEL && I_PENABLE && s_r.pready && !s_r.pslverr;
      if (setup)
      begin
         s_nxt.pready  = 1'b1;
         s_nxt.pslverr = !hit;
         s_nxt.prdata  = 32'h00000000;
         if (hit && !I_PWRITE)
         begin
            s_nxt.prdata = rd_word;
         end
      end
      if (access && I_PWRITE)
      begin
         if (wr_preset[0])
         begin
            s_nxt.preset[0] = I_PWDATA[CNT_W-1:0];
         end
         if (wr_preset[1])
         begin
            s_nxt.preset[1] = I_PWDATA[CNT_W-1:0];
         end
         if (wr_cfg[0])
         begin
            s_nxt.cfg[0]    = I_PWDATA[CFG_W-1:0];
            s_nxt.cfg_wr[0] = 1'b1;
         end
         if (wr_cfg[1])
         begin
            s_nxt.cfg[1]    = I_PWDATA[CFG_W-1:0];
            s_nxt.cfg_wr[1] = 1'b1;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         s_r.cfg     <= {CFG_RESET, CFG_RESET};
         s_r.preset  <= {PRESET_RESET, PRESET_RESET};
         s_r.cfg_wr  <= 2'b00;
         s_r.prdata  <= 32'h00000000;
         s_r.pready  <= 1'b0;
         s_r.pslverr <= 1'b0;
         s_r.running <= 2'b00;
      end
      else if (I_CE)
      begin
         s_r <= s_nxt;
      end
   end

   assign O_PRDATA         = s_r.prdata;
   assign O_PREADY         = s_r.pready;
   assign O_PSLVERR        = s_r.pslverr;
   assign O_FIRST_RUNNING  = s_r.running[0];
   assign O_SECOND_RUNNING = s_r.running[1];

endmodule
`default_nettype wire

//--- test/evtmr_assertions.sv
// Bound checker for the APB answers and event halts of the timer pair.
`timescale 1ns/1ns
`default_nettype none
module evtmr_assertions
   import evtmr_pkg::*;
(
   // Clock and reset
   input wire logic        I_CLK_SYS,
   input wire logic        I_NRST,
   input wire logic        I_CE,
   // APB
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic [7:0]  I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] O_PRDATA,
   input wire logic        O_PREADY,
   input wire logic        O_PSLVERR,
   // Events and state
   input wire logic        I_RX_NIBBLE,
   input wire logic        I_TX_BEGIN,
   input wire logic        I_FAR_FIELD_UP,
   input wire logic        I_FAR_FIELD_DOWN,
   input wire logic        I_OWN_FIELD_UP,
   input wire logic        I_OWN_FIELD_DOWN,
   input wire logic        O_FIRST_RUNNING,
   input wire logic        O_SECOND_RUNNING
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_NRST);
   logic [CFG_W-1:0] c0_r;
   logic [CFG_W-1:0] c1_r;
   logic             set_w;
   logic             wr_w;
   logic             ok_w;
   logic [5:0]       ev_w;
   assign set_w = I_PSEL && !I_PENABLE && I_CE;
   // Writes land at the access edge that completes an accepted transfer.
   assign wr_w  = I_PSEL && I_PENABLE && O_PREADY && !O_PSLVERR && I_PWRITE && I_CE;
   assign ok_w  = I_PADDR[1:0] == 2'h0 &&
                  I_PADDR[7:2] inside {6'h08, 6'h09, 6'h0B, 6'h0C, 6'h0E, 6'h0F};
   assign ev_w  = {I_RX_NIBBLE, I_TX_BEGIN, I_FAR_FIELD_UP, I_FAR_FIELD_DOWN,
                   I_OWN_FIELD_UP, I_OWN_FIELD_DOWN};
   // Shadow of both configurations, so halt checks know which events are armed.
   always_ff @(posedge I_CLK_SYS or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         c0_r <= CFG_RESET;
         c1_r <= CFG_RESET;
      end
      else if (wr_w && I_PADDR == 8'h38)
         c0_r <= I_PWDATA[CFG_W-1:0];
      else if (wr_w && I_PADDR == 8'h3C)
         c1_r <= I_PWDATA[CFG_W-1:0];
   end
   ////////////////////////////////////////////////////////////
   sequence s_halt0;
      c0_r[CFG_ON] && |(ev_w & c0_r[20:15]) && I_CE ##1 I_CE;
   endsequence
   sequence s_halt1;
      c1_r[CFG_ON] && |(ev_w & c1_r[20:15]) && I_CE ##1 I_CE;
   endsequence
   property p_ready;  set_w |=> O_PREADY; endproperty
   property p_pulse;  O_PREADY && I_CE |=> !O_PREADY; endproperty
   property p_bad;    set_w && !ok_w |=> O_PSLVERR && O_PRDATA == 32'h0; endproperty
   property p_good;   set_w && ok_w |=> !O_PSLVERR; endproperty
   property p_errrdy; O_PSLVERR |-> O_PREADY; endproperty
   property p_hold;   !set_w |=> $stable(O_PRDATA); endproperty
   property p_halt0;  s_halt0 |-> ##1 !O_FIRST_RUNNING; endproperty
   property p_halt1;  s_halt1 |-> ##1 !O_SECOND_RUNNING; endproperty
   property p_dis0;   !c0_r[CFG_ON] [*4] |-> !O_FIRST_RUNNING; endproperty
   property p_dis1;   !c1_r[CFG_ON] [*4] |-> !O_SECOND_RUNNING; endproperty
   a_ready:  assert property (p_ready) else $error("no ready after setup");
   a_pulse:  assert property (p_pulse) else $error("ready too long");
   a_bad:    assert property (p_bad) else $error("bad address accepted");
   a_good:   assert property (p_good) else $error("good address refused");
   a_errrdy: assert property (p_errrdy) else $error("error without ready");
   a_hold:   assert property (p_hold) else $error("read data moved");
   a_halt0:  assert property (p_halt0) else $error("first timer not halted");
   a_halt1:  assert property (p_halt1) else $error("second timer not halted");
   a_dis0:   assert property (p_dis0) else $error("first timer runs disabled");
   a_dis1:   assert property (p_dis1) else $error("second timer runs disabled");
endmodule
bind evtmr_top evtmr_assertions chk_u
(
   .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_CE(I_CE), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
   .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
   .I_RX_NIBBLE(I_RX_NIBBLE), .I_TX_BEGIN(I_TX_BEGIN), .I_FAR_FIELD_UP(I_FAR_FIELD_UP),
   .I_FAR_FIELD_DOWN(I_FAR_FIELD_DOWN), .I_OWN_FIELD_UP(I_OWN_FIELD_UP),
   .I_OWN_FIELD_DOWN(I_OWN_FIELD_DOWN), .O_FIRST_RUNNING(O_FIRST_RUNNING),
   .O_SECOND_RUNNING(O_SECOND_RUNNING)
);
`default_nettype wire

//--- test/event_triggered_countdown_timer_tb_top.sv
// Self-checking bench for the event triggered countdown timer pair.
`timescale 1ns/1ns
`default_nettype none
module event_triggered_countdown_timer_tb_top
   import evtmr_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        tick = 1'b0;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  padr = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [8:0]  ev = 9'h000;
   logic [31:0] prd;
   logic [31:0] rdat;
   logic        prdy;
   logic        perr;
   logic        rerr;
   logic        run0;
   logic        run1;
   int          fails = 0;
   int          checked = 0;
   logic [7:0]  adr[6] = '{8'h20, 8'h24, 8'h2C, 8'h30, 8'h38, 8'h3C};
   logic [7:0]  bad[3] = '{8'h28, 8'h3A, 8'h40};
   int          st_ev[8] = '{8, 7, 6, 5, 4, 3, 2, 0};
   int          sp_ev[6] = '{8, 7, 6, 5, 3, 1};
   always #2 clk = ~clk;
   evtmr_top dut_u
   (
      .I_CLK_SYS(clk), .I_NRST(nrst), .I_CE(ce), .I_FE_TICK(tick),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
      .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
      .I_RX_BEGIN(ev[0]), .I_RX_NIBBLE(ev[1]), .I_RX_END(ev[2]), .I_TX_BEGIN(ev[3]),
      .I_TX_END(ev[4]), .I_FAR_FIELD_UP(ev[5]), .I_FAR_FIELD_DOWN(ev[6]),
      .I_OWN_FIELD_UP(ev[7]), .I_OWN_FIELD_DOWN(ev[8]),
      .O_FIRST_RUNNING(run0), .O_SECOND_RUNNING(run1)
   );
   ////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // A dead slave is left to the watchdog, which ends the run as a failure.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (prdy !== 1'b1);
      rdat = prd;
      rerr = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFFFFFF);
      bus(1'b0, a, 32'h0);
      cmp(rdat & m, e);
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      ev <= 9'h001 << i;
      @(posedge clk);
      ev <= 9'h000;
   endtask
   task automatic fe(input int n);
      repeat (n)
      begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      foreach (adr[i])
         rc(adr[i], 32'h0);
      foreach (bad[i])
      begin
         bus(i[0], bad[i], 32'hFFFFFFFF);
         cmp({31'h0, rerr}, 32'h1);
         cmp(rdat, 32'h0);
      end
      bus(1'b1, 8'h2C, 32'hFFFFFFFF);
      rc(8'h2C, 32'h000FFFFF);
      bus(1'b1, 8'h2C, 32'h0);
      // All trigger bits at once: the halt must win over the start on one event.
      bus(1'b1, 8'h38, 32'hFFFFFFFF);
      rc(8'h38, 32'h001FFFFF);
      bus(1'b1, 8'h20, 32'hFFFFFFFF);
      cmp({31'h0, rerr}, 32'h0);
      rc(8'h20, 32'h00100000);
      pulse(3);
      rc(8'h20, 32'h0);
      bus(1'b1, 8'h38, 32'h0);
      bus(1'b1, 8'h2C, 32'h5);
      bus(1'b1, 8'h38, 32'h41);
      rc(8'h20, 32'h00100005);
      cmp({31'h0, run0}, 32'h1);
      // Ticks while the clock enable is low must not move the count.
      ce <= 1'b0;
      fe(2);
      ce <= 1'b1;
      rc(8'h20, 32'h00100005);
      fe(3);
      rc(8'h20, 32'h00100002);
      fe(2);
      rc(8'h20, 32'h0);
      fe(1);
      rc(8'h20, 32'h0);
      cmp({31'h0, run0}, 32'h0);
      bus(1'b1, 8'h2C, 32'h3);
      bus(1'b1, 8'h38, 32'h43);
      fe(8);
      rc(8'h20, 32'h00100000, 32'h00100000);
      // Whole multiples of the divider make the count independent of its phase.
      for (int k = 0; k < 8; k++)
      begin
         bus(1'b1, 8'h38, 32'h45 | (k << CFG_DIV_LSB));
         fe(4 << k);
         rc(8'h20, 32'h00100001);
      end
      bus(1'b1, 8'h38, 32'h0);
      rc(8'h20, 32'h00000001);
      bus(1'b1, 8'h30, 32'h7);
      foreach (st_ev[i])
      begin
         bus(1'b1, 8'h3C, 32'h1 << (i + CFG_GO_OWN_DOWN));
         pulse(st_ev[i]);
         rc(8'h24, 32'h0, 32'h00100000);
         bus(1'b1, 8'h3C, (32'h1 << (i + CFG_GO_OWN_DOWN)) | 32'h1);
         pulse(1);
         rc(8'h24, 32'h0, 32'h00100000);
         pulse(st_ev[i]);
         rc(8'h24, 32'h00100007);
         cmp({31'h0, run1}, 32'h1);
         bus(1'b1, 8'h3C, 32'h0);
      end
      foreach (sp_ev[i])
      begin
         bus(1'b1, 8'h3C, (32'h1 << (i + CFG_HALT_OWN_DN)) | 32'h41);
         pulse(0);
         rc(8'h24, 32'h00100007);
         pulse(sp_ev[i]);
         rc(8'h24, 32'h00000007);
      end
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end
endmodule
`default_nettype wire
